// ===== wdt_pkg.sv
// Constants and carrier types for the supervisor watchdog.
// Assumes a single 50 MHz reference clock.
package wdt_pkg;

  localparam int unsigned CLK_HZ = 50000000;
  // Times in their own unit, counts derived from the clock rate
  localparam int unsigned TIMEOUT_OPEN_MS = 1600;
  localparam int unsigned TIMEOUT_PULLUP_MS = 200;
  localparam int unsigned SETUP_US = 150;
  localparam int unsigned DETECT_US = 381;
  localparam int unsigned HOLD_MS = 200;
  localparam int unsigned TIMEOUT_OPEN_CYC = TIMEOUT_OPEN_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMEOUT_PULLUP_CYC = TIMEOUT_PULLUP_MS * (CLK_HZ / 1000);
  localparam int unsigned SETUP_CYC = SETUP_US * (CLK_HZ / 1000000);
  localparam int unsigned DETECT_CYC = DETECT_US * (CLK_HZ / 1000000);
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  // Capacitor mode: timeout in us = slope_centi * cap_pf / 100 + offset
  // standard 3.23 ms/nF = 3.23 us/pF, 0.381 ms; extended 77.4 us/pF, 55 ms
  localparam int unsigned STD_SLOPE_CENTI = 323;
  localparam int unsigned STD_OFFSET_US = 381;
  localparam int unsigned EXT_SLOPE_CENTI = 7740;
  localparam int unsigned EXT_OFFSET_US = 55000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;

  localparam int CNT_W = 40;
  localparam int CAP_W = 20;

  typedef enum logic [1:0] {CFG_OPEN, CFG_PULLUP, CFG_CAP} cfg_mode_type;

  typedef enum logic [2:0] {
    ST_RESET, ST_DETECT, ST_OFF, ST_SETUP, ST_RUN, ST_FAULT
  } wd_state_type;

  typedef struct packed {
    logic supply_good;
    logic power_on_ok;
    logic [1:0] config_class;
    logic [CAP_W-1:0] cap_pf;
    logic extended;
  } supply_cfg_type;

  localparam logic [CNT_W-1:0] CNT_ZERO = 40'h00_0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 40'h00_0000_0001;

endpackage

// ===== wdt_edge_sync.sv
// Two-stage synchroniser with falling edge detect on the stage after it.
// Assumes the input may change at any time relative to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module wdt_edge_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic raw_in,
  output logic fall_pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic fall;
  } sync_state_type;

  sync_state_type st_q;
  sync_state_type st_d;

  // First stage only feeds the second, fall compares later stages
  always_comb begin
    st_d = st_q;
    st_d.s1 = raw_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.fall = st_q.s3 & ~st_q.s2;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, fall: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign fall_pulse = st_q.fall;
endmodule
`default_nettype wire

// ===== supervisor_watchdog_timer.sv
// Watchdog timer of a voltage supervisor: kick monitor and fault output.
// Assumes supply and config classification arrive as synchronous levels.
// What this block does
// - Fault goes on its own output, never on the reset output.
// - Once asserted, fault stays low for the reset hold time unless supply is lost.
// - While reset is low, fault output is released.
// - On reset release, timing restarts and kicks are heard again.
// - Enable low: timer off, kicks ignored, no new fault asserted; a fault in progress is held.
// - Enable high: normal timing; enable may change any time.
// - After enable rises in the off state, kicks ignored for a setup period.
// - Below operating level, reset held low and fault released.
// - Interval between falling kick edges is measured against the timeout.
// - Reset output follows supply-good and power-on-ok only; fault released during reset.
// - Open or pulled-up pin gives fixed timeout; capacitor gives adjustable.
// - Fixed timeouts 1600 ms open, 200 ms pulled up.
// - Capacitor mode ends timeout at the charge threshold.
// - Standard: timeout ms = 3.23 * nF + 0.381.
// - Extended: timeout ms = 77.4 * nF + 55.
// - Config pin classified each time supply becomes valid.
// - Only a falling kick edge counts.
// - On supply return, reset held low for hold time then released.
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_timer
  import wdt_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_COUNT = CNT_W'(HOLD_CYC),
  parameter logic [CNT_W-1:0] SETUP_COUNT = CNT_W'(SETUP_CYC),
  parameter logic [CNT_W-1:0] DETECT_COUNT = CNT_W'(DETECT_CYC),
  parameter logic [CNT_W-1:0] OPEN_COUNT = CNT_W'(TIMEOUT_OPEN_CYC),
  parameter logic [CNT_W-1:0] PULLUP_COUNT = CNT_W'(TIMEOUT_PULLUP_CYC)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire wdt_pkg::supply_cfg_type supply_in,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_enable_pin,
  output logic reset_out_n_o,
  output logic reset_out_n_oe,
  output logic watchdog_fault_out_o,
  output logic watchdog_fault_out_oe,
  output wdt_pkg::cfg_mode_type config_mode
);
  import wdt_pkg::*;

  typedef struct packed {
    wd_state_type state;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] timeout;
    logic rst_low;
    logic fault_oe;
    cfg_mode_type mode;
  } wd_type;

  wd_type s_q;
  wd_type s_d;
  logic kick;
  logic [CNT_W-1:0] cap_us;

  wdt_edge_sync u_kick_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw_in(watchdog_kick_in),
    .fall_pulse(kick)
  );

  // Capacitor timeout in microseconds, then cycles; slopes kept in hundredths
  always_comb begin
    if (supply_in.extended) begin
      cap_us = CNT_W'((64'(supply_in.cap_pf) * EXT_SLOPE_CENTI) / 64'h64 + EXT_OFFSET_US);
    end else begin
      cap_us = CNT_W'((64'(supply_in.cap_pf) * STD_SLOPE_CENTI) / 64'h64 + STD_OFFSET_US);
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.fault_oe = 1'b0;
    if (!supply_in.supply_good || !supply_in.power_on_ok) begin
      // Supply low: reset asserted, watchdog frozen and released
      s_d.state = ST_RESET;
      s_d.rst_low = 1'b1;
      s_d.rst_cnt = CNT_ZERO;
    end else begin
      case (s_q.state)
        ST_RESET: begin
          s_d.state = ST_DETECT;
          s_d.rst_cnt = CNT_ZERO;
        end
        ST_DETECT: begin
          s_d.rst_cnt = s_q.rst_cnt + CNT_ONE;
          if (s_q.rst_cnt + CNT_ONE >= DETECT_COUNT) begin
            // Classification retaken each cycle from the detect time until the hold ends
            s_d.mode = cfg_mode_type'(supply_in.config_class);
            if (supply_in.config_class == CFG_CAP) begin
              s_d.timeout = cap_us * CNT_W'(CYC_PER_US);
            end else if (supply_in.config_class == CFG_PULLUP) begin
              s_d.timeout = PULLUP_COUNT;
            end else begin
              s_d.timeout = OPEN_COUNT;
            end
          end
          // Reset hold runs alongside detection; detect is far shorter
          if (s_q.rst_cnt >= HOLD_COUNT) begin
            s_d.rst_low = 1'b0;
            s_d.wd_cnt = CNT_ZERO;
            s_d.state = watchdog_enable_pin ? ST_RUN : ST_OFF;
          end
        end
        ST_OFF: begin
          // Kicks ignored, fault stays released
          if (watchdog_enable_pin) begin
            s_d.state = ST_SETUP;
            s_d.wd_cnt = CNT_ZERO;
          end
        end
        ST_SETUP: begin
          s_d.wd_cnt = s_q.wd_cnt + CNT_ONE;
          if (!watchdog_enable_pin) begin
            s_d.state = ST_OFF;
          end else if (s_q.wd_cnt + CNT_ONE >= SETUP_COUNT) begin
            s_d.state = ST_RUN;
            s_d.wd_cnt = CNT_ZERO;
          end
        end
        ST_RUN: begin
          s_d.wd_cnt = s_q.wd_cnt + CNT_ONE;
          if (!watchdog_enable_pin) begin
            s_d.state = ST_OFF;
          end else if (kick) begin
            s_d.wd_cnt = CNT_ZERO;
          end else if (s_q.wd_cnt + CNT_ONE >= s_q.timeout) begin
            // Missed kick flags only the fault pin, not reset
            s_d.state = ST_FAULT;
            s_d.wd_cnt = CNT_ZERO;
            s_d.fault_oe = 1'b1;
          end
        end
        ST_FAULT: begin
          // Held for the full hold time even if disabled meanwhile
          s_d.wd_cnt = s_q.wd_cnt + CNT_ONE;
          s_d.fault_oe = 1'b1;
          if (s_q.wd_cnt + CNT_ONE >= HOLD_COUNT) begin
            s_d.fault_oe = 1'b0;
            s_d.wd_cnt = CNT_ZERO;
            s_d.state = watchdog_enable_pin ? ST_RUN : ST_OFF;
          end
        end
        default: begin
          s_d.state = ST_RESET;
        end
      endcase
      if (!watchdog_enable_pin) begin
        if (s_q.state != ST_FAULT) begin
          s_d.fault_oe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: ST_RESET, wd_cnt: '0, rst_cnt: '0, timeout: '0,
               rst_low: 1'b1, fault_oe: 1'b0, mode: CFG_OPEN};
    end else begin
      s_q <= s_d;
    end
  end

  // Open-drain pins: low driven only while enabled, output value is fixed low
  assign reset_out_n_o = 1'b0;
  assign reset_out_n_oe = s_q.rst_low;
  assign watchdog_fault_out_o = 1'b0;
  assign watchdog_fault_out_oe = s_q.fault_oe;
  assign config_mode = s_q.mode;
endmodule
`default_nettype wire

// ===== wdt_monitor.sv
// Checker on the watchdog top-level ports.
// Assumes the bind hands down the shortened hold count.
`timescale 1ns/1ps
`default_nettype none
module wdt_monitor
  import wdt_pkg::*;
#(parameter logic [CNT_W-1:0] HOLD_COUNT = CNT_W'(HOLD_CYC)) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire wdt_pkg::supply_cfg_type supply_in,
  input wire logic watchdog_enable_pin,
  input wire logic reset_out_n_o,
  input wire logic reset_out_n_oe,
  input wire logic watchdog_fault_out_o,
  input wire logic watchdog_fault_out_oe,
  input wire wdt_pkg::cfg_mode_type config_mode
);
  logic [CNT_W-1:0] high_q;
  wire good = supply_in.supply_good & supply_in.power_on_ok;
  // Length of the current fault pulse, so the hold can be checked at its end
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) high_q <= CNT_ZERO;
    else high_q <= watchdog_fault_out_oe ? high_q + CNT_ONE : CNT_ZERO;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_od; !reset_out_n_o && !watchdog_fault_out_o; endproperty
  a_od: assert property (p_od) else $error("pin data not low");
  // Reset may only be raised by a supply loss, never by a watchdog fault
  property p_sep; $rose(reset_out_n_oe) |-> !$past(good); endproperty
  a_sep: assert property (p_sep) else $error("reset raised without supply loss");
  property p_loss; !good |=> reset_out_n_oe; endproperty
  a_loss: assert property (p_loss) else $error("reset not asserted");
  property p_rel; reset_out_n_oe |-> !watchdog_fault_out_oe; endproperty
  a_rel: assert property (p_rel) else $error("fault driven in reset");
  property p_hold; $fell(watchdog_fault_out_oe) && !reset_out_n_oe |-> high_q == HOLD_COUNT; endproperty
  a_hold: assert property (p_hold) else $error("fault hold length");
  property p_max; high_q <= HOLD_COUNT; endproperty
  a_max: assert property (p_max) else $error("fault held too long");
  property p_off; !watchdog_enable_pin [*4] |=> !$rose(watchdog_fault_out_oe); endproperty
  a_off: assert property (p_off) else $error("fault while disabled");
  property p_ret; $rose(good) |=> reset_out_n_oe [*8]; endproperty
  a_ret: assert property (p_ret) else $error("reset released early");
  property p_cfg; !reset_out_n_oe && !$past(reset_out_n_oe) |-> $stable(config_mode); endproperty
  a_cfg: assert property (p_cfg) else $error("config changed");
  c_fault: cover property ($rose(watchdog_fault_out_oe));
  c_ready: cover property ($fell(reset_out_n_oe));
  c_en: cover property ($rose(watchdog_enable_pin));
endmodule
`default_nettype wire

// ===== host_kicker.sv
// Host model: pulls the kick pin low for four cycles once each period.
// Assumes run and period come from the bench; the pin idles high.
`timescale 1ns/1ps
`default_nettype none
module host_kicker (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [15:0] period,
  output logic kick
);
  logic [15:0] cnt_q;
  always_ff @(posedge ref_clk) cnt_q <= (!run || cnt_q >= period - 16'h1) ? 16'h0 : cnt_q + 16'h1;
  // Wide pulses; only the falling edge restarts the timer
  assign kick = !(run && cnt_q < 16'h4);
endmodule
`default_nettype wire

// ===== tb.sv
// Bench: power-up per config class, timeouts, kick intervals, disable.
// Assumes host_kicker on the kick pin; long counts shortened by parameters.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdt_pkg::*;
  logic ref_clk = 1'b0, rst_n, en, run, roe, foe, kick, seen;
  logic [15:0] per;
  supply_cfg_type sup;
  cfg_mode_type mode;
  int fail_count, compares, n;
  supervisor_watchdog_timer #(.HOLD_COUNT(40'h32), .SETUP_COUNT(40'hA), .DETECT_COUNT(40'h5),
    .OPEN_COUNT(40'h190), .PULLUP_COUNT(40'hC8)) u_dut (.ref_clk, .rst_n, .supply_in(sup),
    .watchdog_kick_in(kick), .watchdog_enable_pin(en), .reset_out_n_o(), .reset_out_n_oe(roe),
    .watchdog_fault_out_o(), .watchdog_fault_out_oe(foe), .config_mode(mode));
  host_kicker u_host (.ref_clk, .run, .period(per), .kick);
  initial forever #10 ref_clk = ~ref_clk;
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wt(input logic f, input logic v, input int lim);
    for (n = 0; (f ? foe : roe) !== v; n++) begin
      @(negedge ref_clk);
      if (n >= lim) begin
        chk(1'b0, "wait ran out");
        print_verdict();
      end
    end
  endtask
  task automatic tmo(input int t);
    wt(1'b1, 1'b1, t + 10);
    chk(n >= t - 3 && n <= t + 6, "timeout");
    wt(1'b1, 1'b0, 60);
    chk(n == 50 && roe === 1'b0, "fault hold");
    $display("timeout %0d done", t);
  endtask
  task automatic power_up(input logic [1:0] c, input int t);
    sup.supply_good = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(roe === 1'b1 && foe === 1'b0, "supply loss");
    {sup.config_class, sup.supply_good} = {c, 1'b1};
    wt(1'b0, 1'b0, 80);
    chk(n >= 50 && n <= 54, "reset hold");
    chk(mode === cfg_mode_type'(c), "config class");
    $display("power_up %0d done", c);
    tmo(t);
  endtask
  task automatic kicks(input logic [15:0] p, input logic e, input logic f);
    {per, en, run, seen} = {p, e, 2'b10};
    repeat (800) @(negedge ref_clk) seen |= foe === 1'b1;
    chk(seen === f, "kick interval");
    {run, en} = 2'b01;
    // Let an edge pass so the next scenario never re-drives run or en in this step
    @(negedge ref_clk);
    wt(1'b1, 1'b0, 60);
    $display("kicks %0d done", p);
  endtask
  initial begin
    {rst_n, run, en, per} = {1'b0, 1'b0, 1'b1, 16'h96};
    sup = '{1'b0, 1'b1, 2'h1, 20'h0, 1'b0};
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    power_up(2'h1, 200);
    tmo(200);
    kicks(16'h96, 1'b1, 1'b0);
    kicks(16'h104, 1'b1, 1'b1);
    kicks(16'h104, 1'b0, 1'b0);
    tmo(210);
    wt(1'b1, 1'b1, 300);
    power_up(2'h0, 400);
    power_up(2'h2, 19050);
    // 100 pF adds 323 us to the 381 us offset: 704 us
    sup.cap_pf = 20'h64;
    @(negedge ref_clk);
    power_up(2'h2, 35200);
    print_verdict();
  end
endmodule
bind supervisor_watchdog_timer wdt_monitor #(.HOLD_COUNT(HOLD_COUNT)) u_mon (.ref_clk, .rst_n,
  .supply_in, .watchdog_enable_pin, .reset_out_n_o, .reset_out_n_oe, .watchdog_fault_out_o,
  .watchdog_fault_out_oe, .config_mode);
`default_nettype wire
